/* File: common/wsc_pkg.sv */
// register map, field layout, reset values and timing for the wake/shutdown controller
package wsc_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam int             ADDR_W         = 8;
  localparam logic [7:0]     OFF_CMD        = 8'h00;
  localparam logic [7:0]     OFF_CFG        = 8'h04;
  localparam logic [7:0]     OFF_FLAGS      = 8'h08;
  localparam logic [7:0]     OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0]     OFF_IRQ_MASK   = 8'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int             KEY_LSB        = 24;
  localparam int             KEY_MSB        = 31;
  localparam int             CMD_BIT        = 0;
  localparam int             EDGE_LSB       = 0;
  localparam int             EDGE_MSB       = 1;
  localparam int             DEB_LSB        = 4;
  localparam int             DEB_MSB        = 7;
  localparam int             ALARM_EN_BIT   = 16;
  localparam int             PIN_FLAG_BIT   = 0;
  localparam int             ALARM_FLAG_BIT = 16;
  localparam logic [7:0]     CMD_KEY        = 8'hA5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [1:0]     EDGE_RST       = 2'h3;
  localparam logic [3:0]     DEB_RST        = 4'h0;
  localparam logic           ALARM_EN_RST   = 1'b0;
  localparam logic [1:0]     IRQ_MASK_RST   = 2'h0;

  // ****************************************
  // edge modes
  // ****************************************
  localparam logic [1:0]     EDGE_NONE      = 2'h0;
  localparam logic [1:0]     EDGE_RISE      = 2'h1;
  localparam logic [1:0]     EDGE_FALL      = 2'h2;
  localparam logic [1:0]     EDGE_ANY       = 2'h3;

  // ****************************************
  // timing, in slow-clock cycles, and debounce counter width in bits
  // ****************************************
  localparam int             CMD_DELAY      = 2;
  localparam int             DEBOUNCE_UNIT  = 16;
  localparam int             CNT_W          = 8;

  typedef enum logic [1:0]
  {
    DEB_IDLE  = 2'b01,
    DEB_COUNT = 2'b10
  } wsc_deb_state_type;

endpackage

/* File: verilog/wsc_top.sv */
// wake/shutdown controller: power-off output, debounced wake pin, alarm wake, registers
//
// Local design decision: strobed register access.
`timescale 1ns/10ps

// Contract
// - command bit 1 with right key asserts power-off; command bit 0 does nothing
// - top byte must be 0xA5, otherwise the whole command write is dropped
// - edge select: 00 off, 01 rising, 10 falling, 11 any change
// - wake level must persist debounce count times 16 cycles before a wake event
// - power-off releases debounce count times 16 plus 1 cycles after the event
// - alarm wake disabled: alarm ignored, power-off unchanged
// - alarm wake enabled: alarm releases power-off
// - pin wake flag sets on wake, sticks, clears on flags register read
// - alarm wake flag sets on alarm wake, sticks, clears on flags register read
// - accepted command reaches power-off output two cycles after the write
// - block runs on the free-running slow clock, never gated
// - a new pin change before the count completes clears the counter; a qualifying edge restarts it at one
// - alarm is synchronised and only its rising edge is used
module wsc_top
#(
  parameter int DEBOUNCE_UNIT = wsc_pkg::DEBOUNCE_UNIT
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  // pins
  input  wire logic        wake_pin_in,
  input  wire logic        alarm_timer,
  output logic             power_off_out,
  // interrupt
  output logic             irq
);

  localparam int CW = wsc_pkg::CNT_W;

  // ****************************************
  // elaboration checks
  // ****************************************
  // the longest debounce window must fit the counter
  if (DEBOUNCE_UNIT < 1 || DEBOUNCE_UNIT * 15 >= (1 << CW))
  begin : g_bad_unit
    $error("debounce unit does not fit the counter");
  end

  // ****************************************
  // state
  // ****************************************
  logic                         pin_s1;
  logic                         pin_s2;
  logic                         pin_s3;
  logic                         alarm_s1;
  logic                         alarm_s2;
  logic                         alarm_s3;
  logic [1:0]                   wake_edge_select;
  logic [3:0]                   wake_debounce_count;
  logic                         alarm_wake_enable;
  logic                         pin_wake_flag;
  logic                         alarm_wake_flag;
  logic [1:0]                   irq_status;
  logic [1:0]                   irq_mask;
  logic [1:0]                   cmd_stage;
  logic [CW-1:0]                deb_cnt;
  wsc_pkg::wsc_deb_state_type   deb_state;
  wsc_pkg::wsc_deb_state_type   next_deb_state;
  logic [CW-1:0]                next_deb_cnt;

  // ****************************************
  // decode
  // ****************************************
  wire        hit_cmd    = addr == wsc_pkg::OFF_CMD;
  wire        hit_cfg    = addr == wsc_pkg::OFF_CFG;
  wire        hit_flags  = addr == wsc_pkg::OFF_FLAGS;
  wire        hit_status = addr == wsc_pkg::OFF_IRQ_STATUS;
  wire        hit_mask   = addr == wsc_pkg::OFF_IRQ_MASK;
  wire        key_ok     = wdata[wsc_pkg::KEY_MSB:wsc_pkg::KEY_LSB] == wsc_pkg::CMD_KEY;
  wire        cmd_accept = wr_en && hit_cmd && key_ok && wdata[wsc_pkg::CMD_BIT];
  wire        rd_flags   = rd_en && hit_flags;

  // ****************************************
  // wake pin edge detection
  // ****************************************
  wire        pin_rise   = pin_s2 & ~pin_s3;
  wire        pin_fall   = ~pin_s2 & pin_s3;
  wire        pin_change = pin_s2 ^ pin_s3;
  wire        pin_det    = (wake_edge_select == wsc_pkg::EDGE_RISE && pin_rise)
                        || (wake_edge_select == wsc_pkg::EDGE_FALL && pin_fall)
                        || (wake_edge_select == wsc_pkg::EDGE_ANY && pin_change);
  wire [CW-1:0] cnt_target = CW'(wake_debounce_count * DEBOUNCE_UNIT);
  // turning detection off abandons a count in progress, so no late wake follows
  wire        det_off    = wake_edge_select == wsc_pkg::EDGE_NONE;
  wire        cnt_done   = deb_state == wsc_pkg::DEB_COUNT && !pin_change && !det_off
                        && deb_cnt == cnt_target;
  // zero count releases on the detection cycle itself
  wire        pin_wake   = (pin_det && cnt_target == '0) || cnt_done;

  // ****************************************
  // alarm edge
  // ****************************************
  wire        alarm_rise = alarm_s2 & ~alarm_s3;
  wire        alarm_wake = alarm_rise & alarm_wake_enable;
  wire        wake_any   = pin_wake | alarm_wake;

  // ****************************************
  // flags and interrupt next values
  // ****************************************
  // a wake in the reading cycle survives the read
  wire        next_pin_flag   = pin_wake | (pin_wake_flag & ~rd_flags);
  wire        next_alarm_flag = alarm_wake | (alarm_wake_flag & ~rd_flags);
  wire [1:0]  irq_clear       = (wr_en && hit_status) ?
                                {wdata[wsc_pkg::ALARM_FLAG_BIT], wdata[wsc_pkg::PIN_FLAG_BIT]} : 2'h0;
  wire [1:0]  next_irq_status = {alarm_wake, pin_wake} | (irq_status & ~irq_clear);
  wire [1:0]  next_irq_mask   = (wr_en && hit_mask) ?
                                {wdata[wsc_pkg::ALARM_FLAG_BIT], wdata[wsc_pkg::PIN_FLAG_BIT]} : irq_mask;

  // ****************************************
  // read mux
  // ****************************************
  wire [31:0] cfg_word    = {15'h0000, alarm_wake_enable, 8'h00, wake_debounce_count, 2'h0, wake_edge_select};
  wire [31:0] flags_word  = {15'h0000, alarm_wake_flag, 15'h0000, pin_wake_flag};
  wire [31:0] status_word = {15'h0000, irq_status[1], 15'h0000, irq_status[0]};
  wire [31:0] mask_word   = {15'h0000, irq_mask[1], 15'h0000, irq_mask[0]};
  wire [31:0] read_word   = hit_cfg    ? cfg_word    :
                            hit_flags  ? flags_word  :
                            hit_status ? status_word :
                            hit_mask   ? mask_word   : 32'h0000_0000;

  // ****************************************
  // debounce state machine
  // ****************************************
  always_comb
  begin
    next_deb_state = deb_state;
    next_deb_cnt   = deb_cnt;
    unique case (deb_state)
      wsc_pkg::DEB_IDLE:
      begin
        if (pin_det && cnt_target != '0)
        begin
          next_deb_state = wsc_pkg::DEB_COUNT;
          next_deb_cnt   = CW'(1);
        end
      end
      wsc_pkg::DEB_COUNT:
      begin
        if (pin_change || det_off)
        begin
          // a fresh qualifying edge restarts, any other change abandons
          next_deb_state = pin_det ? wsc_pkg::DEB_COUNT : wsc_pkg::DEB_IDLE;
          next_deb_cnt   = pin_det ? CW'(1) : '0;
        end
        else if (cnt_done)
        begin
          next_deb_state = wsc_pkg::DEB_IDLE;
          next_deb_cnt   = '0;
        end
        else
        begin
          next_deb_cnt = deb_cnt + CW'(1);
        end
      end
      default:
      begin
        next_deb_state = wsc_pkg::DEB_IDLE;
        next_deb_cnt   = '0;
      end
    endcase
  end

  // ****************************************
  // flip-flops; clk is the always-running slow clock
  // ****************************************
  // synchronisers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1   <= 1'b0;
      pin_s2   <= 1'b0;
      pin_s3   <= 1'b0;
      alarm_s1 <= 1'b0;
      alarm_s2 <= 1'b0;
      alarm_s3 <= 1'b0;
    end
    else
    begin
      pin_s1   <= wake_pin_in;
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      alarm_s1 <= alarm_timer;
      alarm_s2 <= alarm_s1;
      alarm_s3 <= alarm_s2;
    end
  end

  // configuration
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_edge_select    <= wsc_pkg::EDGE_RST;
      wake_debounce_count <= wsc_pkg::DEB_RST;
      alarm_wake_enable   <= wsc_pkg::ALARM_EN_RST;
      irq_mask            <= wsc_pkg::IRQ_MASK_RST;
    end
    else
    begin
      if (wr_en && hit_cfg)
      begin
        wake_edge_select    <= wdata[wsc_pkg::EDGE_MSB:wsc_pkg::EDGE_LSB];
        wake_debounce_count <= wdata[wsc_pkg::DEB_MSB:wsc_pkg::DEB_LSB];
        alarm_wake_enable   <= wdata[wsc_pkg::ALARM_EN_BIT];
      end
      irq_mask <= next_irq_mask;
    end
  end

  // command pipeline and power-off output
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_stage     <= 2'h0;
      power_off_out <= 1'b0;
    end
    else
    begin
      cmd_stage <= {cmd_stage[0], cmd_accept};
      // a wake in the same cycle as the command landing wins
      if (wake_any)
        power_off_out <= 1'b0;
      else if (cmd_stage[wsc_pkg::CMD_DELAY-1])
        power_off_out <= 1'b1;
    end
  end

  // debounce, flags, interrupt, read data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      deb_state       <= wsc_pkg::DEB_IDLE;
      deb_cnt         <= '0;
      pin_wake_flag   <= 1'b0;
      alarm_wake_flag <= 1'b0;
      irq_status      <= 2'h0;
      irq             <= 1'b0;
      rdata           <= 32'h0000_0000;
    end
    else
    begin
      deb_state       <= next_deb_state;
      deb_cnt         <= next_deb_cnt;
      pin_wake_flag   <= next_pin_flag;
      alarm_wake_flag <= next_alarm_flag;
      irq_status      <= next_irq_status;
      irq             <= |(next_irq_status & next_irq_mask);
      rdata           <= rd_en ? read_word : 32'h0000_0000;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  cmd_delay_a: assert property ((cmd_accept ##2 !wake_any) |=> power_off_out)
    else $error("accepted command did not assert power-off two cycles later");
  key_guard_a: assert property ((wr_en && hit_cmd && !key_ok) |=> !cmd_stage[0])
    else $error("command with wrong key was taken");
  zero_cmd_a: assert property ((wr_en && hit_cmd && !wdata[wsc_pkg::CMD_BIT] && !power_off_out
                                && cmd_stage == 2'h0) |=> !cmd_stage[0] ##2 !power_off_out)
    else $error("command bit zero changed power-off");
  edge_off_a: assert property ((wake_edge_select == wsc_pkg::EDGE_NONE) |-> !pin_wake && !pin_det)
    else $error("wake detected with detection disabled");
  zero_release_a: assert property ((pin_det && cnt_target == '0 && power_off_out) |=> !power_off_out)
    else $error("zero debounce did not release at once");
  count_hold_a: assert property ((deb_state == wsc_pkg::DEB_COUNT && !pin_change && !cnt_done && !det_off)
                                 |-> !pin_wake ##1 deb_cnt == $past(deb_cnt) + CW'(1))
    else $error("debounce released early or stalled");
  bounce_clear_a: assert property ((deb_state == wsc_pkg::DEB_COUNT && pin_change && !pin_det)
                                   |=> deb_cnt == '0 && deb_state == wsc_pkg::DEB_IDLE)
    else $error("counter not cleared on bounce");
  alarm_off_a: assert property ((alarm_rise && !alarm_wake_enable && !pin_wake && power_off_out
                                 && !cmd_stage[1] && !alarm_wake_flag) |=> power_off_out && !alarm_wake_flag)
    else $error("disabled alarm acted");
  alarm_on_a: assert property ((alarm_wake && power_off_out) |=> !power_off_out && alarm_wake_flag)
    else $error("enabled alarm did not release power-off");
  flag_sticky_a: assert property ((pin_wake_flag && !rd_flags) |=> pin_wake_flag)
    else $error("pin wake flag dropped without a read");
  alarm_sync_a: assert property (alarm_wake |-> alarm_s2 && !$past(alarm_s2))
    else $error("alarm used without rising edge");
  out_hold_a: assert property ((power_off_out && !wake_any) |=> power_off_out)
    else $error("power-off released without a wake");

  shutdown_c: cover property (cmd_accept ##2 1'b1 ##1 power_off_out);
  pin_wake_c: cover property (power_off_out && cnt_done ##1 !power_off_out);
  alarm_wake_c: cover property (power_off_out && alarm_wake ##1 !power_off_out);
  bounce_c: cover property (deb_state == wsc_pkg::DEB_COUNT && pin_change && !pin_det);

endmodule

/* File: verification/wsc_wake_partner.sv */
// far-side model: wake push-button, timer alarm source and main supply converter
`timescale 1ns/10ps
module wsc_wake_partner
(
  // requests from the bench
  input  wire logic press,
  input  wire logic alarm_req,
  // controller side
  input  wire logic power_off_out,
  output logic      wake_pin_in,
  output logic      alarm_timer,
  // converter state
  output logic      supply_on
);
  // the button and the alarm are plain levels, driven and held by whoever asks for them
  assign wake_pin_in = press;
  assign alarm_timer = alarm_req;
  // converter keeps the main supply up only while shutdown is not requested
  assign supply_on   = ~power_off_out;
endmodule

/* File: verification/tb.sv */
// self-checking bench for the wake/shutdown controller
`timescale 1ns/10ps
module tb;
  // ****************************************
  // signals and instances
  // ****************************************
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata;
  logic        press;
  logic        alarm_req;
  logic        wake_pin_in;
  logic        alarm_timer;
  logic        power_off_out;
  logic        irq;
  logic        supply_on;
  int          errors;
  int          num_checks;
  int          cycles;

  wsc_top #(.DEBOUNCE_UNIT(16)) i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .wake_pin_in(wake_pin_in), .alarm_timer(alarm_timer),
    .power_off_out(power_off_out), .irq(irq));
  wsc_wake_partner i_partner (.press(press), .alarm_req(alarm_req), .power_off_out(power_off_out),
    .wake_pin_in(wake_pin_in), .alarm_timer(alarm_timer), .supply_on(supply_on));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic shut();
    wr(wsc_pkg::OFF_CMD, 32'hA500_0001);
    repeat (3) @(posedge clk);
  endtask

  // raise the pin or the alarm and count edges until the converter is let back on
  task automatic release_time(input logic use_alarm, input logic [31:0] exp_n);
    int n;
    n = 0;
    @(posedge clk);
    if (use_alarm)
      alarm_req <= 1'b1;
    else
      press <= 1'b1;
    while (power_off_out === 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n, exp_n);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_registers();
    rd_chk(wsc_pkg::OFF_CFG, 32'h0000_0003);
    rd_chk(wsc_pkg::OFF_FLAGS, 32'h0);
    rd_chk(wsc_pkg::OFF_CMD, 32'h0);
    rd_chk(8'h20, 32'h0);
    wr(wsc_pkg::OFF_CFG, 32'h0001_00F2);
    rd_chk(wsc_pkg::OFF_CFG, 32'h0001_00F2);
    check(power_off_out, 1'b0);
  endtask

  task automatic t_command();
    wr(wsc_pkg::OFF_CMD, 32'h5A00_0001);
    repeat (4) @(posedge clk);
    check(power_off_out, 1'b0);
    wr(wsc_pkg::OFF_CMD, 32'hA500_0000);
    repeat (4) @(posedge clk);
    check(power_off_out, 1'b0);
    @(posedge clk);
    addr  <= wsc_pkg::OFF_CMD;
    wdata <= 32'hA500_0001;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
    check(power_off_out, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    check(power_off_out, 1'b1);
    check(supply_on, 1'b0);
    repeat (60) @(posedge clk);
    check(power_off_out, 1'b1);
  endtask

  task automatic t_pin_timing();
    wr(wsc_pkg::OFF_CFG, 32'h0000_0011);
    shut();
    release_time(1'b0, 32'd19);
    rd_chk(wsc_pkg::OFF_FLAGS, 32'h1);
    rd_chk(wsc_pkg::OFF_FLAGS, 32'h0);
    @(posedge clk);
    press <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // a pulse shorter than the debounce window must not wake, and clears the count
  task automatic t_glitch();
    shut();
    @(posedge clk);
    press <= 1'b1;
    repeat (10) @(posedge clk);
    press <= 1'b0;
    repeat (8) @(posedge clk);
    check(power_off_out, 1'b1);
    release_time(1'b0, 32'd19);
    rd_chk(wsc_pkg::OFF_FLAGS, 32'h1);
    @(posedge clk);
    press <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      wr(wsc_pkg::OFF_CFG, 32'(m));
      shut();
      @(posedge clk);
      press <= 1'b1;
      repeat (8) @(posedge clk);
      check(power_off_out, 32'(m == 0 || m == 2));
      press <= 1'b0;
      repeat (8) @(posedge clk);
      check(power_off_out, 32'(m == 0));
      rd_chk(wsc_pkg::OFF_FLAGS, 32'(m != 0));
    end
  endtask

  task automatic t_alarm();
    wr(wsc_pkg::OFF_CFG, 32'h0);
    shut();
    @(posedge clk);
    alarm_req <= 1'b1;
    repeat (8) @(posedge clk);
    check(power_off_out, 1'b1);
    alarm_req <= 1'b0;
    rd_chk(wsc_pkg::OFF_FLAGS, 32'h0);
    wr(wsc_pkg::OFF_CFG, 32'h0001_0000);
    shut();
    release_time(1'b1, 32'd3);
    shut();
    repeat (10) @(posedge clk);
    check(power_off_out, 1'b1);
    rd_chk(wsc_pkg::OFF_FLAGS, 32'h0001_0000);
    rd_chk(wsc_pkg::OFF_FLAGS, 32'h0);
  endtask

  // status stays pending while masked; the line follows mask and write-one-to-clear
  task automatic t_irq();
    check(irq, 1'b0);
    wr(wsc_pkg::OFF_IRQ_MASK, 32'h0001_0000);
    repeat (2) @(posedge clk);
    #1;
    check(irq, 1'b1);
    rd_chk(wsc_pkg::OFF_IRQ_STATUS, 32'h0001_0001);
    wr(wsc_pkg::OFF_IRQ_STATUS, 32'h0001_0001);
    repeat (2) @(posedge clk);
    #1;
    check(irq, 1'b0);
    rd_chk(wsc_pkg::OFF_IRQ_STATUS, 32'h0);
    alarm_req <= 1'b0;
  endtask

  // ****************************************
  // sequence and hang guard
  // ****************************************
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  initial
  begin
    rst_n      = 1'b0;
    addr       = 8'h00;
    wdata      = 32'h0;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    press      = 1'b0;
    alarm_req  = 1'b0;
    errors     = 0;
    num_checks = 0;
    cycles     = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_registers();
    t_command();
    t_pin_timing();
    t_glitch();
    t_modes();
    t_alarm();
    t_irq();
    end_of_test();
  end
endmodule
